// File: rtl/rdarb_pkg.sv
// rdarb_pkg: constants and carriers for the refresh arbiter host controller
package rdarb_pkg;

  localparam int CLK_MHZ           = 250;
  localparam int ADDR_W            = 6;
  localparam int CNT_W             = 16;
  localparam int BURST_ROWS        = 64;
  localparam int REFRESH_PERIOD_MS = 2;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * CLK_MHZ * 1000;
  localparam int LAUNCH_DELAY_NS   = 20;
  localparam int MEM_CYCLE_NS      = 400;
  localparam int BUSY_SETUP_NS     = 120;

  // least times round up to whole cycles
  localparam int LAUNCH_CYC = (LAUNCH_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int MEM_CYC    = (MEM_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC  = (BUSY_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC   = (MEM_CYC > SETUP_CYC) ? MEM_CYC : SETUP_CYC;

  localparam logic [CNT_W-1:0] LAUNCH_CNT = CNT_W'(LAUNCH_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(HOLD_CYC - 1);
  localparam logic [6:0]       ROWS_CNT   = 7'(BURST_ROWS);
  localparam int               DEV_W      = 4 + ADDR_W;

  // pins driven by the refresh controller, idle high
  typedef struct packed {
    logic              start_n;
    logic              ack_n;
    logic              refresh_active_n_n;
    logic              timer_n;
    logic [ADDR_W-1:0] row_n;
  } rdarb_dev_t;

  localparam rdarb_dev_t DEV_IDLE = '{start_n: 1'b1, ack_n: 1'b1, refresh_active_n_n: 1'b1,
                                      timer_n: 1'b1, row_n: {ADDR_W{1'b1}}};

  typedef enum logic [1:0] {
    BUSY_IDLE,
    BUSY_LAUNCH,
    BUSY_HOLD,
    BUSY_RELEASE
  } rdarb_busy_t;

endpackage : rdarb_pkg

// File: rtl/rdarb_sync.sv
// rdarb_sync: two-flop synchroniser, one stage pair per bit
module rdarb_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys_in,  // system clock
  input  wire logic         rst_n_in,    // async reset, active low
  input  wire logic         clk_en_in,   // freezes state while low
  input  wire logic [W-1:0] d_in,        // asynchronous input
  output logic      [W-1:0] q_out        // synchronised output
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_reg[i] <= RST_VAL[i];
        sync_reg[i] <= RST_VAL[i];
      end else if (clk_en_in) begin
        meta_reg[i] <= d_in[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign q_out = sync_reg;

endmodule : rdarb_sync

// File: rtl/rdarb_host.sv
// rdarb_host: requester, busy latch and refresh pacing around the refresh arbiter
module rdarb_host
  import rdarb_pkg::*;
#(
  parameter int REFRESH_CYC = REFRESH_PERIOD_CYC,
  parameter int ROWS        = BURST_ROWS
) (
  input  wire logic              clk_sys_in,             // 250 MHz system clock
  input  wire logic              rst_n_in,               // async reset, active low
  input  wire logic              clk_en_in,              // freezes state while low
  input  wire logic              sys_req_in,             // request a system cycle
  input  wire logic [ADDR_W-1:0] sys_addr_in,            // low-order address of request
  input  wire logic              burst_mode_in,          // 1 burst, 0 distributed
  output logic                   sys_ready_out,          // request can be taken
  output logic                   sys_done_out,           // system cycle finished
  output logic                   refresh_done_out,       // refresh cycle finished
  output logic                   mem_launch_out,         // launch array timing
  output logic                   grant_refresh_out,      // current cycle is refresh
  output logic [ADDR_W-1:0]      row_addr_out,           // row seen on address pins
  output logic                   cycle_request_n_out,    // cycle request pin
  output logic                   refresh_request_n_out,  // refresh request pin
  output logic                   busy_n_out,             // busy latch pin
  output logic [ADDR_W-1:0]      sys_addr_pin_out,       // address pins to device
  input  wire logic              start_cycle_out_n_in,   // start-cycle from device
  input  wire logic              ack_n_in,               // acknowledge from device
  input  wire logic              refresh_active_n_in,    // refresh-on from device
  input  wire logic              refresh_timer_n_in,     // timer latch from device
  input  wire logic [ADDR_W-1:0] mem_row_addr_out_n_in   // inverted addresses
);

  localparam int PER_W = $clog2(REFRESH_CYC + 1);
  localparam int LAUNCH_A = LAUNCH_CYC;
  localparam logic [PER_W-1:0] PER_LAST = PER_W'(REFRESH_CYC - 1);

  rdarb_dev_t  dev_raw;
  rdarb_dev_t  dev;
  rdarb_busy_t busy_state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [PER_W-1:0] period_reg;
  logic [6:0]       burst_left_reg;
  logic             cyc_req_reg;
  logic             ref_req_reg;
  logic             grant_sys_reg;
  logic             grant_ref_reg;

  assign dev_raw = '{start_n: start_cycle_out_n_in, ack_n: ack_n_in,
                     refresh_active_n_n: refresh_active_n_in, timer_n: refresh_timer_n_in,
                     row_n: mem_row_addr_out_n_in};

  rdarb_sync #(
    .W       (DEV_W),
    .RST_VAL (DEV_IDLE)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .d_in       (dev_raw),
    .q_out      (dev)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // busy latch and memory timing

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_state_reg <= BUSY_IDLE;
      cnt_reg        <= '0;
      busy_n_out     <= 1'b1;
      mem_launch_out <= 1'b0;
    end else if (clk_en_in) begin
      mem_launch_out <= 1'b0;
      unique case (busy_state_reg)
        BUSY_IDLE: begin
          if (!dev.start_n) begin
            busy_n_out     <= 1'b0;
            cnt_reg        <= LAUNCH_CNT;
            busy_state_reg <= BUSY_LAUNCH;
          end
        end
        BUSY_LAUNCH: begin
          if (cnt_reg == '0) begin
            mem_launch_out <= 1'b1;
            cnt_reg        <= HOLD_CNT;
            busy_state_reg <= BUSY_HOLD;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        BUSY_HOLD: begin
          if (cnt_reg == '0) begin
            busy_state_reg <= BUSY_RELEASE;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        BUSY_RELEASE: begin
          // no release while our request still stands granted
          if (!(cyc_req_reg && grant_sys_reg) && !(ref_req_reg && grant_ref_reg)) begin
            busy_n_out     <= 1'b1;
            busy_state_reg <= BUSY_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // grant capture and completion

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_sys_reg    <= 1'b0;
      grant_ref_reg    <= 1'b0;
      row_addr_out     <= '0;
      sys_done_out     <= 1'b0;
      refresh_done_out <= 1'b0;
    end else if (clk_en_in) begin
      sys_done_out     <= 1'b0;
      refresh_done_out <= 1'b0;
      if (busy_state_reg == BUSY_HOLD) begin
        if (!dev.refresh_active_n_n) begin
          grant_ref_reg <= 1'b1;
        end else if (!dev.ack_n) begin
          grant_sys_reg <= 1'b1;
        end
        row_addr_out <= ~dev.row_n;
      end else if (busy_state_reg == BUSY_RELEASE && busy_n_out == 1'b0
                   && !(cyc_req_reg && grant_sys_reg)
                   && !(ref_req_reg && grant_ref_reg)) begin
        sys_done_out     <= grant_sys_reg;
        refresh_done_out <= grant_ref_reg;
        grant_sys_reg    <= 1'b0;
        grant_ref_reg    <= 1'b0;
      end
    end
  end

  assign grant_refresh_out = grant_ref_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // system cycle requester

  // no new request while busy: the address pins must hold for the running cycle
  assign sys_ready_out = !cyc_req_reg && busy_n_out;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_req_reg      <= 1'b0;
      sys_addr_pin_out <= '0;
    end else if (clk_en_in) begin
      if (sys_ready_out && sys_req_in) begin
        cyc_req_reg      <= 1'b1;
        sys_addr_pin_out <= sys_addr_in;
      // release once busy low and accepted
      end else if (cyc_req_reg && !busy_n_out && !dev.ack_n) begin
        cyc_req_reg <= 1'b0;
      end
    end
  end

  assign cycle_request_n_out = !cyc_req_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // refresh pacing

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_reg     <= '0;
      burst_left_reg <= '0;
    end else if (clk_en_in) begin
      if (!burst_mode_in) begin
        period_reg     <= '0;
        burst_left_reg <= '0;
      end else if (period_reg == PER_LAST) begin
        period_reg     <= '0;
        burst_left_reg <= 7'(ROWS);
      end else begin
        period_reg <= period_reg + PER_W'(1);
        if (ref_req_reg && !busy_n_out && !dev.refresh_active_n_n) begin
          burst_left_reg <= burst_left_reg - 7'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_req_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!burst_mode_in) begin
        ref_req_reg <= !dev.timer_n;
      end else if (ref_req_reg && !busy_n_out && !dev.refresh_active_n_n) begin
        ref_req_reg <= 1'b0;
      end else if (!ref_req_reg && busy_n_out && burst_left_reg != '0) begin
        ref_req_reg <= 1'b1;
      end
    end
  end

  assign refresh_request_n_out = !ref_req_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence busy_fall_s;
    $fell(busy_n_out);
  endsequence

  sequence launch_s;
    ##LAUNCH_A mem_launch_out;
  endsequence

  busy_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    busy_fall_s |-> !busy_n_out [*8])
    else $error("busy released too early");

  busy_start_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (clk_en_in && busy_state_reg == BUSY_IDLE && !dev.start_n) |=> !busy_n_out)
    else $error("busy not set on start");

  launch_delay_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in || !clk_en_in)
    busy_fall_s |-> launch_s)
    else $error("launch not at delay");

  req_release_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (clk_en_in && cyc_req_reg && !sys_req_in && !busy_n_out && !dev.ack_n)
    |=> cycle_request_n_out)
    else $error("cycle request held after ack");

  req_before_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(busy_n_out) |-> !($past(cyc_req_reg) && $past(grant_sys_reg)))
    else $error("busy rose with granted request low");

  // burst requests only while rows remain
  burst_req_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (burst_mode_in && $rose(ref_req_reg)) |-> $past(burst_left_reg) != '0)
    else $error("refresh request with no rows left");

  timer_tie_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (clk_en_in && !burst_mode_in) |=> (refresh_request_n_out == $past(dev.timer_n)))
    else $error("refresh request not tied to timer");

  grant_excl_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(grant_sys_reg && grant_ref_reg))
    else $error("both grants held");

  // done pulses only as busy rises
  done_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (sys_done_out || refresh_done_out) |-> $rose(busy_n_out))
    else $error("done without busy release");

endmodule : rdarb_host

// File: dv/rdarb_dev_model.sv
// rdarb_dev_model: behavioural refresh arbiter device on the far side
module rdarb_dev_model
  import rdarb_pkg::*;
#(
  parameter int TIMER_CYC = 600
) (
  input  wire logic              clk_sys_in,           // system clock
  input  wire logic              rst_n_in,             // async reset, active low
  input  wire logic              cycle_request_n_in,   // cycle request pin
  input  wire logic              refresh_request_n_in, // refresh request pin
  input  wire logic              busy_n_in,            // busy latch pin
  input  wire logic [ADDR_W-1:0] addr_in,              // system address pins
  output rdarb_dev_t             dev_out               // device output pins
);
  logic [1:0]        grant_reg;
  logic              busy_d_reg;
  logic              start_reg;
  logic              ack_reg;
  logic              refresh_active_n_reg;
  logic              timer_reg;
  logic [ADDR_W-1:0] row_reg;
  logic [15:0]       tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_reg  <= 2'h0;
      busy_d_reg <= 1'b1;
      start_reg  <= 1'b1;
      ack_reg    <= 1'b1;
      refresh_active_n_reg  <= 1'b1;
    end else begin
      busy_d_reg <= busy_n_in;
      if (busy_n_in && !busy_d_reg) begin
        grant_reg <= 2'h0;
        ack_reg   <= 1'b1;
        refresh_active_n_reg <= 1'b1;
      end else if (!busy_n_in) begin
        start_reg <= 1'b1;
        if (grant_reg == 2'h1) begin
          ack_reg <= 1'b0;
        end
      end else if (grant_reg == 2'h0) begin
        if (!refresh_request_n_in) begin
          grant_reg <= 2'h2;
          start_reg <= 1'b0;
          refresh_active_n_reg <= 1'b0;
        end else if (!cycle_request_n_in) begin
          grant_reg <= 2'h1;
          start_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      row_reg <= '0;
    end else if (busy_n_in && !busy_d_reg && grant_reg == 2'h2) begin
      row_reg <= row_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_reg  <= '0;
      timer_reg <= 1'b1;
    end else begin
      tick_reg <= (tick_reg == 16'(TIMER_CYC - 1)) ? 16'h0000 : tick_reg + 16'h0001;
      if (tick_reg == 16'(TIMER_CYC - 1)) begin
        timer_reg <= 1'b0;
      end else if (grant_reg == 2'h2) begin
        timer_reg <= 1'b1;
      end
    end
  end

  assign dev_out = '{start_n: start_reg, ack_n: ack_reg, refresh_active_n_n: refresh_active_n_reg, timer_n: timer_reg,
                     row_n: (!busy_n_in && grant_reg == 2'h2) ? ~row_reg : ~addr_in};
endmodule : rdarb_dev_model

// File: dv/rdarb_host_tb.sv
// rdarb_host_tb: self-checking bench for the refresh arbiter host
module rdarb_host_tb
  import rdarb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int REF_CYC = 2000;
  localparam int NROWS   = 4;

  logic              clk_sys_in, rst_n_in, sys_req_in, burst_mode_in, clk_en_in;
  logic [ADDR_W-1:0] sys_addr_in, row_addr_out, sys_addr_pin_out, exp_row;
  logic              sys_ready_out, sys_done_out, refresh_done_out, mem_launch_out;
  logic              grant_refresh_out, cycle_request_n_out, refresh_request_n_out, busy_n_out;
  rdarb_dev_t        dev;
  int                num_errors, n_compared;

  rdarb_host #(.REFRESH_CYC(REF_CYC), .ROWS(NROWS)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .sys_req_in(sys_req_in),
    .sys_addr_in(sys_addr_in), .burst_mode_in(burst_mode_in), .sys_ready_out(sys_ready_out),
    .sys_done_out(sys_done_out), .refresh_done_out(refresh_done_out),
    .mem_launch_out(mem_launch_out), .grant_refresh_out(grant_refresh_out),
    .row_addr_out(row_addr_out), .cycle_request_n_out(cycle_request_n_out),
    .refresh_request_n_out(refresh_request_n_out), .busy_n_out(busy_n_out),
    .sys_addr_pin_out(sys_addr_pin_out), .start_cycle_out_n_in(dev.start_n),
    .ack_n_in(dev.ack_n), .refresh_active_n_in(dev.refresh_active_n_n),
    .refresh_timer_n_in(dev.timer_n), .mem_row_addr_out_n_in(dev.row_n));

  rdarb_dev_model #(.TIMER_CYC(600)) model (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cycle_request_n_in(cycle_request_n_out),
    .refresh_request_n_in(refresh_request_n_out), .busy_n_in(busy_n_out),
    .addr_in(sys_addr_pin_out), .dev_out(dev));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  // hold the request until the edge at which ready is sampled high
  task automatic issue_req(input logic [ADDR_W-1:0] addr);
    int   n;
    logic ok;
    n  = 0;
    ok = 1'b0;
    @(posedge clk_sys_in);
    sys_req_in  <= 1'b1;
    sys_addr_in <= addr;
    while (ok !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_in);
      ok = sys_ready_out;
      @(posedge clk_sys_in);
      n++;
    end
    sys_req_in <= 1'b0;
    chk(ok === 1'b1, "request not taken");
  endtask : issue_req

  // clock enable low: a request must not be taken
  task automatic t_freeze();
    @(posedge clk_sys_in);
    clk_en_in  <= 1'b0;
    sys_req_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    sys_req_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(cycle_request_n_out === 1'b1, "request taken while frozen");
    @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
  endtask : t_freeze

  // one whole memory cycle seen from busy fall to release
  task automatic run_cycle(input logic is_ref, input logic [ADDR_W-1:0] addr);
    int   n;
    int   la;
    logic rq;
    logic g;
    n  = 0;
    la = -1;
    rq = 1'b0;
    g  = 1'bx;
    while (busy_n_out !== 1'b0 && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    n = 0;
    while (busy_n_out === 1'b0 && n < 1000) begin
      if (mem_launch_out === 1'b1) la = n;
      rq = is_ref ? refresh_request_n_out : cycle_request_n_out;
      g  = grant_refresh_out;
      @(negedge clk_sys_in);
      n++;
    end
    chk(la == LAUNCH_CYC, "launch delay");
    chk(n >= LAUNCH_CYC + HOLD_CYC + 1, "busy too short");
    chk(rq === 1'b1, "request still low at busy end");
    chk(g === is_ref, "grant kind");
    chk((is_ref ? refresh_done_out : sys_done_out) === 1'b1, "done pulse");
    chk(row_addr_out === addr, "address pins");
  endtask : run_cycle

  task automatic t_reset();
    chk(busy_n_out === 1'b1, "busy after reset");
    chk(cycle_request_n_out === 1'b1, "cycle request after reset");
    chk(refresh_request_n_out === 1'b1, "refresh request after reset");
    chk(sys_ready_out === 1'b1, "ready after reset");
  endtask : t_reset

  task automatic t_sys_pair();
    fork
      begin
        issue_req(6'h3F);
        issue_req(6'h15);
      end
    join_none
    run_cycle(1'b0, 6'h3F);
    run_cycle(1'b0, 6'h15);
  endtask : t_sys_pair

  task automatic t_distributed();
    repeat (2) begin
      run_cycle(1'b1, exp_row);
      exp_row = exp_row + 1'b1;
    end
  endtask : t_distributed

  task automatic t_burst();
    realtime t1;
    burst_mode_in <= 1'b1;
    run_cycle(1'b1, exp_row);
    t1 = $realtime;
    exp_row = exp_row + 1'b1;
    fork
      issue_req(6'h2A);
    join_none
    repeat (NROWS - 1) begin
      run_cycle(1'b1, exp_row);
      exp_row = exp_row + 1'b1;
    end
    chk($realtime - t1 < REF_CYC * 4.0, "burst too slow");
    run_cycle(1'b0, 6'h2A);
  endtask : t_burst

  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #80000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    rst_n_in      = 1'b0;
    sys_req_in    = 1'b0;
    burst_mode_in = 1'b0;
    clk_en_in     = 1'b1;
    sys_addr_in   = '0;
    exp_row       = '0;
    num_errors    = 0;
    n_compared    = 0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(negedge clk_sys_in);
    t_reset();
    t_freeze();
    t_sys_pair();
    t_distributed();
    t_burst();
    summarize();
  end
endmodule : rdarb_host_tb
